// [design/tsr_task_state_unit.sv]
// Purpose: task switch save/load engine and port permission checker
// Assumes: record memory answers with a one-cycle ack on the same clock
// Notes:   Avalon slave answers every access one cycle after it appears
`include "tsr_consts.svh"

module tsr_task_state_unit
  import tsr_pkg::*;
#(
  parameter int CTX_WORDS = 27
) (
  input  wire logic        clk_sys_in,          // system clock
  input  wire logic        rst_n_in,            // async reset, low
  input  wire logic [5:0]  avs_address_in,      // word address
  input  wire logic        avs_read_in,         // read request
  input  wire logic        avs_write_in,        // write request
  input  wire logic [31:0] avs_writedata_in,    // write data
  input  wire logic [3:0]  avs_byteenable_in,   // write lanes
  output logic      [31:0] avs_readdata_out,    // read data
  output logic             avs_waitrequest_out, // stall
  output logic             mem_req_out,         // record access
  output logic             mem_we_out,          // write access
  output logic      [31:0] mem_addr_out,        // byte address
  output logic      [31:0] mem_wdata_out,       // write word
  input  wire logic [31:0] mem_rdata_in,        // read word
  input  wire logic        mem_ack_in,          // access done
  output logic             done_out,            // command done pulse
  output logic             gp_fault_out,        // protection fault pulse
  output logic             db_fault_out,        // debug fault pulse
  output logic             ts_fault_out         // bad record pulse
);

  // lane merge for byte enables
  function automatic tsr_word_t merge(tsr_word_t old, tsr_word_t nw,
                                      logic [3:0] be);
    tsr_word_t r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // words written on suspend
  function automatic logic is_dyn(logic [4:0] i);
    return (i == `TSR_W_LINK) || (i >= `TSR_W_NIP && i <= `TSR_W_LASTDY);
  endfunction

  // byte lane of a word
  function automatic logic [7:0] pick(tsr_word_t w, logic [1:0] lo);
    return w[{lo, 3'b000} +: 8];
  endfunction

  // word to byte address
  function automatic tsr_word_t waddr(tsr_word_t base, logic [4:0] i);
    return base + {25'h0, i, 2'b00};
  endfunction

  tsr_state_t       state, next_state;
  logic [4:0]       idx, next_idx;
  tsr_word_t        ctx [CTX_WORDS];
  tsr_word_t        next_ctx [CTX_WORDS];
  tsr_word_t        old_base, next_old_base;
  tsr_word_t        new_base, next_new_base;
  tsr_word_t        new_limit, next_new_limit;
  tsr_word_t        cur_base, next_cur_base;
  tsr_word_t        cur_limit, next_cur_limit;
  logic [5:0]       cfg, next_cfg;
  logic [17:0]      io_req, next_io_req;
  logic [15:0]      task_ptr, next_task_ptr;
  logic             task_busy, next_task_busy;
  logic [16:0]      ioff, next_ioff;
  logic [7:0]       byte0, next_byte0;
  logic [4:0]       st, next_st;
  logic             next_mem_req, next_mem_we;
  tsr_word_t        next_mem_addr, next_mem_wdata;
  logic             next_done, next_gp, next_db, next_ts;
  logic             next_wait;
  tsr_word_t        next_rdata;
  logic             wr_go;
  logic             acc;
  logic [4:0]       last_ld;
  logic [15:0]      map_mask;
  logic [15:0]      map_pair;
  tsr_word_t        rd_mux;

  // bus handshake: one wait cycle, then answer
  assign acc   = (avs_read_in | avs_write_in) & avs_waitrequest_out;
  assign wr_go = avs_write_in & ~avs_waitrequest_out;
  // last word loaded, shadow pointer only with shadow stacks
  assign last_ld = cfg[`TSR_F_SHADOW] ? `TSR_W_SHADOW : `TSR_W_TRAP; // see [RQ11]
  // covered bits of a 1, 2 or 4 byte port, or one redirect vector bit (size 3)
  assign map_mask = {12'h000, (io_req[17:16] == 2'b10 ? 4'hF : (io_req[17:16] == 2'b01 ? 4'h3
                    : 4'h1))} << io_req[2:0]; // see [RQ15]

  // read data selection
  always_comb begin
    rd_mux = `TSR_RST_WORD;
    if (avs_address_in >= `TSR_A_CTX &&
        avs_address_in < `TSR_A_CTX + 6'(CTX_WORDS)) begin
      rd_mux = ctx[5'(avs_address_in - `TSR_A_CTX)];
    end else begin
      unique case (avs_address_in)
        `TSR_A_STATUS:    rd_mux = {25'h0, task_busy, st, state != TSR_IDLE};
        `TSR_A_OLD_BASE:  rd_mux = old_base;
        `TSR_A_NEW_BASE:  rd_mux = new_base;
        `TSR_A_NEW_LIMIT: rd_mux = new_limit;
        `TSR_A_CFG:       rd_mux = {26'h0, cfg};
        `TSR_A_IO_REQ:    rd_mux = {14'h0, io_req};
        `TSR_A_TASK_PTR:  rd_mux = {16'h0, task_ptr};
        `TSR_A_CUR_BASE:  rd_mux = cur_base;
        `TSR_A_CUR_LIMIT: rd_mux = cur_limit;
        default:          rd_mux = `TSR_RST_WORD;
      endcase
    end
  end

  // bus slave next values
  always_comb begin
    next_wait  = ~acc;
    next_rdata = (acc & avs_read_in) ? rd_mux : avs_readdata_out;
  end

  // bus slave registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= `TSR_RST_WORD;
    end else begin
      avs_waitrequest_out <= next_wait;
      avs_readdata_out    <= next_rdata;
    end
  end

  // engine next values
  always_comb begin
    logic fin, gp, db, ts, grant, cmd_ok;
    fin   = 1'b0;
    gp    = 1'b0;
    db    = 1'b0;
    ts    = 1'b0;
    grant = 1'b0;
    cmd_ok = wr_go && avs_address_in == `TSR_A_CTRL && state == TSR_IDLE;
    next_state     = state;
    next_idx       = idx;
    next_ctx       = ctx;
    next_old_base  = old_base;
    next_new_base  = new_base;
    next_new_limit = new_limit;
    next_cur_base  = cur_base;
    next_cur_limit = cur_limit;
    next_cfg       = cfg;
    next_io_req    = io_req;
    next_task_ptr  = task_ptr;
    next_task_busy = task_busy;
    next_ioff      = ioff;
    next_byte0     = byte0;
    next_mem_req   = 1'b0;
    next_mem_we    = mem_we_out;
    next_mem_addr  = mem_addr_out;
    next_mem_wdata = mem_wdata_out;
    map_pair       = 16'h0000;
    // software writes, accepted only while idle
    if (wr_go && state == TSR_IDLE) begin
      if (avs_address_in >= `TSR_A_CTX &&
          avs_address_in < `TSR_A_CTX + 6'(CTX_WORDS)) begin
        next_ctx[5'(avs_address_in - `TSR_A_CTX)] =
          merge(ctx[5'(avs_address_in - `TSR_A_CTX)], avs_writedata_in,
                avs_byteenable_in);
      end
      unique case (avs_address_in)
        `TSR_A_OLD_BASE:  next_old_base = merge(old_base, avs_writedata_in,
                                                avs_byteenable_in);
        `TSR_A_NEW_BASE:  next_new_base = merge(new_base, avs_writedata_in,
                                                avs_byteenable_in);
        `TSR_A_NEW_LIMIT: next_new_limit = merge(new_limit, avs_writedata_in,
                                                 avs_byteenable_in);
        `TSR_A_CFG:       next_cfg = 6'(merge({26'h0, cfg}, avs_writedata_in,
                                              avs_byteenable_in));
        `TSR_A_IO_REQ:    next_io_req = 18'(merge({14'h0, io_req},
                                                  avs_writedata_in,
                                                  avs_byteenable_in));
        `TSR_A_TASK_PTR:  next_task_ptr = 16'(merge({16'h0, task_ptr},
                                                    avs_writedata_in,
                                                    avs_byteenable_in));
        default: ;
      endcase
    end
    unique case (state)
      TSR_IDLE: begin
        if (cmd_ok && avs_writedata_in[`TSR_C_SWITCH]) begin
          if (new_limit < (cfg[`TSR_F_SHADOW] ? `TSR_MIN_LIM_SS
                                               : `TSR_MIN_LIM)) begin
            ts  = 1'b1; // see [RQ24]
            fin = 1'b1;
          end else begin
            next_state = TSR_SAVE; // see [RQ23]
            next_idx   = `TSR_W_LINK;
          end
        end else if (cmd_ok && avs_writedata_in[`TSR_C_IOCHK]) begin
          next_ioff = {1'b0, ctx[`TSR_W_TRAP][31:16]} + ((&io_req[17:16]) ? {12'hFFF, io_req[7:3]}
                      : {4'h0, io_req[15:3]}); // see [RQ13] see [RQ20]
          if (!(cfg[`TSR_F_V86] || cfg[`TSR_F_CURPRV] > cfg[`TSR_F_IOPRV])) begin
            grant = 1'b1; // see [RQ14]
            fin   = 1'b1;
          end else if (ctx[`TSR_W_TRAP][31:16] > `TSR_MAP_MAX ||
                       {15'h0, next_ioff} > cur_limit) begin
            gp  = 1'b1; // see [RQ18] see [RQ19]
            fin = 1'b1;
          end else begin
            next_state = TSR_IO0; // see [RQ16]
          end
        end else if (cmd_ok && avs_writedata_in[`TSR_C_TASKLD]) begin
          next_task_busy = 1'b1; // see [RQ12]
          next_cur_base  = new_base;
          next_cur_limit = new_limit;
          fin            = 1'b1;
        end
      end
      TSR_SAVE: begin
        if (mem_ack_in) begin
          if (idx == `TSR_W_LASTDY) begin
            next_state = TSR_LOAD;
            next_idx   = `TSR_W_LINK;
          end else begin
            next_idx = (idx == `TSR_W_LINK) ? `TSR_W_NIP : idx + 5'd1;
          end
        end else if (!mem_req_out) begin
          next_mem_req   = 1'b1;
          next_mem_we    = 1'b1; // see [RQ1] see [RQ4] see [RQ5] see [RQ6]
          next_mem_addr  = waddr(old_base, idx);
          next_mem_wdata = ctx[idx]; // see [RQ7]
        end else begin
          next_mem_req = 1'b1;
        end
      end
      TSR_LOAD: begin
        if (mem_ack_in) begin
          if (idx >= `TSR_W_SEG0 && idx <= `TSR_W_LOCTBL) begin
            next_ctx[idx] = {16'h0, mem_rdata_in[15:0]}; // see [RQ7] see [RQ8]
          end else begin
            next_ctx[idx] = mem_rdata_in; // see [RQ2] see [RQ3] see [RQ10]
          end
          if (idx == last_ld) begin
            next_state     = TSR_IDLE;
            next_cur_base  = new_base;
            next_cur_limit = new_limit;
            db             = next_ctx[`TSR_W_TRAP][0]; // see [RQ9]
            fin            = 1'b1;
          end else begin
            next_idx = idx + 5'd1;
          end
        end else if (!mem_req_out) begin
          next_mem_req  = 1'b1;
          next_mem_we   = 1'b0;
          next_mem_addr = waddr(new_base, idx); // see [RQ11]
        end else begin
          next_mem_req = 1'b1;
        end
      end
      TSR_IO0: begin
        if (mem_ack_in) begin
          next_byte0 = pick(mem_rdata_in, mem_addr_out[1:0]);
          next_state = TSR_IO1;
        end else if (!mem_req_out) begin
          next_mem_req  = 1'b1;
          next_mem_we   = 1'b0;
          next_mem_addr = cur_base + {15'h0, ioff};
        end else begin
          next_mem_req = 1'b1;
        end
      end
      TSR_IO1: begin
        if ({15'h0, ioff} + 32'h1 > cur_limit) begin
          map_pair   = {`TSR_ONES_BYTE, byte0}; // see [RQ19]
          gp         = |(map_pair & map_mask); // see [RQ15]
          grant      = ~gp;
          fin        = 1'b1;
          next_state = TSR_IDLE;
        end else if (mem_ack_in) begin
          map_pair   = {pick(mem_rdata_in, mem_addr_out[1:0]), byte0};
          gp         = |(map_pair & map_mask); // see [RQ15]
          grant      = ~gp;
          fin        = 1'b1;
          next_state = TSR_IDLE;
        end else if (!mem_req_out) begin
          next_mem_req  = 1'b1;
          next_mem_we   = 1'b0;
          next_mem_addr = cur_base + {15'h0, ioff} + 32'h1; // see [RQ16]
        end else begin
          next_mem_req = 1'b1;
        end
      end
    endcase
    // sticky status: a new event wins over a write-one clear
    next_st = st;
    if (wr_go && avs_address_in == `TSR_A_STATUS) begin
      next_st = st & ~avs_writedata_in[`TSR_S_GRANT:`TSR_S_DONE];
    end
    if (cmd_ok) begin
      next_st[4] = 1'b0;
    end
    next_st = next_st | {grant, ts, db, gp, fin};
    next_done = fin;
    next_gp   = gp;
    next_db   = db;
    next_ts   = ts;
  end

  // engine registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state         <= TSR_IDLE;
      idx           <= 5'h00;
      for (int i = 0; i < CTX_WORDS; i++) begin
        ctx[i] <= `TSR_RST_WORD;
      end
      old_base      <= `TSR_RST_WORD;
      new_base      <= `TSR_RST_WORD;
      new_limit     <= `TSR_RST_WORD;
      cur_base      <= `TSR_RST_WORD;
      cur_limit     <= `TSR_RST_WORD;
      cfg           <= 6'h00;
      io_req        <= 18'h00000;
      task_ptr      <= 16'h0000;
      task_busy     <= 1'b0;
      ioff          <= 17'h00000;
      byte0         <= 8'h00;
      st            <= 5'h00;
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= `TSR_RST_WORD;
      mem_wdata_out <= `TSR_RST_WORD;
      done_out      <= 1'b0;
      gp_fault_out  <= 1'b0;
      db_fault_out  <= 1'b0;
      ts_fault_out  <= 1'b0;
    end else begin
      state         <= next_state;
      idx           <= next_idx;
      ctx           <= next_ctx;
      old_base      <= next_old_base;
      new_base      <= next_new_base;
      new_limit     <= next_new_limit;
      cur_base      <= next_cur_base;
      cur_limit     <= next_cur_limit;
      cfg           <= next_cfg;
      io_req        <= next_io_req;
      task_ptr      <= next_task_ptr;
      task_busy     <= next_task_busy;
      ioff          <= next_ioff;
      byte0         <= next_byte0;
      st            <= next_st;
      mem_req_out   <= next_mem_req;
      mem_we_out    <= next_mem_we;
      mem_addr_out  <= next_mem_addr;
      mem_wdata_out <= next_mem_wdata;
      done_out      <= next_done;
      gp_fault_out  <= next_gp;
      db_fault_out  <= next_db;
      ts_fault_out  <= next_ts;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  a_bus_answer: assert property ( // see [RQ12]
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus access not answered next cycle");
  a_save_first: assert property ( // see [RQ23]
    state == TSR_LOAD && $past(state) != TSR_LOAD |-> $past(state) == TSR_SAVE)
    else $error("load began without save");
  a_write_dyn: assert property ( // see [RQ2]
    mem_req_out && mem_we_out |-> is_dyn(idx) && state == TSR_SAVE)
    else $error("static record word written");
  a_core_only: assert property ( // see [RQ11]
    mem_req_out && state inside {TSR_SAVE, TSR_LOAD} |-> idx <= `TSR_W_SHADOW)
    else $error("switch access beyond record core");
  a_ts_limit: assert property ( // see [RQ24]
    ts_fault_out |-> $past(new_limit) < `TSR_MIN_LIM_SS && done_out)
    else $error("record fault with legal limit");
  a_trap_debug: assert property ( // see [RQ9]
    db_fault_out |-> ctx[`TSR_W_TRAP][0] && $past(state) == TSR_LOAD)
    else $error("debug fault without trap bit");
  a_io_need: assert property ( // see [RQ14]
    state == TSR_IO0 |-> cfg[`TSR_F_V86] || cfg[`TSR_F_CURPRV] > cfg[`TSR_F_IOPRV])
    else $error("map read without need");
  a_idle_quiet: assert property ( // see [RQ12]
    state == TSR_IDLE |-> !mem_req_out)
    else $error("memory access while idle");

  c_switch: cover property (state == TSR_LOAD ##1 state == TSR_IDLE);
  c_io_gp: cover property (state == TSR_IO1 ##1 gp_fault_out);
  c_io_ok: cover property (state == TSR_IO1 ##1 (done_out && !gp_fault_out));
  c_task_load: cover property ($rose(task_busy));

endmodule

// [shared/tsr_consts.svh]
// Purpose: constants of the task state record unit
// Assumes: 32-bit Avalon word addresses, record word index = byte offset / 4
// Notes:   offsets, field positions, reset values and limits live here
//
// Overview of operation
// [RQ1] link word 0 is saved on suspend and reloaded on load.
// [RQ2] level 0-2 stack pairs are loaded only, never written back.
// [RQ3] translation table base is loaded only, never saved.
// [RQ4] next instruction pointer is saved on suspend and restored on load.
// [RQ5] flags image is saved on suspend and restored on load.
// [RQ6] eight general registers are saved and restored as consecutive words.
// [RQ7] six segment selectors use low halves; upper halves ignored on read.
// [RQ8] local descriptor table selector is loaded only, never saved.
// [RQ9] trap bit set in incoming record raises a debug fault.
// [RQ10] shadow stack pointer is loaded only, never saved.
// [RQ11] a switch touches only the first 104 record bytes (plus shadow word).
// [RQ12] load task register op touches no record field and no memory.
// [RQ13] 16-bit field at 66h locates the permission map start.
// [RQ14] map consulted only in v86 mode or when current privilege exceeds io privilege.
// [RQ15] one bit per byte port; any covered set bit gives protection fault.
// [RQ16] two consecutive map bytes are fetched for each port check; here a map byte beyond the record limit is not fetched.
// [RQ17] software ends the map with an all-ones byte plus one more.
// [RQ18] map base above DFFFh gives a protection fault on map access.
// [RQ19] map bits beyond the record limit count as set.
// [RQ20] redirect map holds one bit per software vector, 32 bytes.
// [RQ21] software places both maps above byte 103, inside 64 Kbytes.
// [RQ22] software keeps the record free of page faults during switches.
// [RQ23] outgoing dynamic state is saved before incoming state is loaded.
// [RQ24] record limit below 67h, or 6Bh with shadow stacks, faults.
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH
// bus register word addresses
`define TSR_A_CTRL      6'h00
`define TSR_A_STATUS    6'h01
`define TSR_A_OLD_BASE  6'h02
`define TSR_A_NEW_BASE  6'h03
`define TSR_A_NEW_LIMIT 6'h04
`define TSR_A_CFG       6'h05
`define TSR_A_IO_REQ    6'h06
`define TSR_A_TASK_PTR  6'h07
`define TSR_A_CUR_BASE  6'h08
`define TSR_A_CUR_LIMIT 6'h09
`define TSR_A_CTX       6'h20
// control and status bits
`define TSR_C_SWITCH 0
`define TSR_C_IOCHK  1
`define TSR_C_TASKLD 2
`define TSR_S_BUSY   0
`define TSR_S_DONE   1
`define TSR_S_GP     2
`define TSR_S_DB     3
`define TSR_S_TS     4
`define TSR_S_GRANT  5
`define TSR_S_TBUSY  6
// configuration fields
`define TSR_F_SHADOW 0
`define TSR_F_V86    1
`define TSR_F_CURPRV 3:2
`define TSR_F_IOPRV  5:4
// record word indexes
`define TSR_W_LINK   5'd0
`define TSR_W_NIP    5'd8
`define TSR_W_SEG0   5'd18
`define TSR_W_LASTDY 5'd23
`define TSR_W_LOCTBL 5'd24
`define TSR_W_TRAP   5'd25
`define TSR_W_SHADOW 5'd26
// limits
`define TSR_MIN_LIM    32'h0000_0067
`define TSR_MIN_LIM_SS 32'h0000_006B
`define TSR_MAP_MAX    16'hDFFF
`define TSR_ONES_BYTE  8'hFF
`define TSR_RST_WORD   32'h0000_0000
`endif

// [shared/tsr_pkg.sv]
// Purpose: types of the task state record unit
// Assumes: nothing beyond the constants header
// Notes:   state codes written out
package tsr_pkg;
  typedef enum logic [2:0] {
    TSR_IDLE = 3'b000,
    TSR_SAVE = 3'b001,
    TSR_LOAD = 3'b010,
    TSR_IO0  = 3'b011,
    TSR_IO1  = 3'b100
  } tsr_state_t;
  typedef logic [31:0] tsr_word_t;
endpackage

// [testbench/testbench.sv]
// Purpose: self-checking bench for the task state unit
// Assumes: old record at 000h, new ones at 400h and 800h, map at 480h
// Notes:   register access over the unit's own bus tasks
`include "tsr_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, rd, wr, slow, wreq, mreq, mwe, mack, done, gp, db, ts;
  logic        fd, fg, ft, obad;
  logic [5:0]  adr;
  logic [31:0] wd, rdat, maddr, mwd, mrd, q, v, e;
  int          fails, compares, acc, a0;
  logic [5:0]  io_cfg [14] = '{6'h00, 6'h28, 6'h0C, 6'h2C, 6'h02, 6'h0C,
                               6'h0C, 6'h0C, 6'h0C, 6'h0C, 6'h0C, 6'h0C, 6'h02, 6'h02};
  // last two are redirect map lookups of vectors 82h and 80h (byte 70h = 1Ch)
  logic [17:0] io_req [14] = '{18'h0000C, 18'h0000C, 18'h00000, 18'h0000C, 18'h0000C,
    18'h1000B, 18'h1000A, 18'h20006, 18'h20009, 18'h0003F, 18'h2003E, 18'h00040,
    18'h30082, 18'h30080};
  logic [13:0] io_gp = 14'h1D38; // fault expected per case, case 0 at bit 0

  tsr_task_state_unit tsr_task_state_unit_i (
    .clk_sys_in(clk), .rst_n_in(rst_n), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .mem_req_out(mreq),
    .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_rdata_in(mrd),
    .mem_ack_in(mack), .done_out(done), .gp_fault_out(gp), .db_fault_out(db),
    .ts_fault_out(ts));
  tsr_mem_model tsr_mem_model_i (
    .clk_in(clk), .rst_n_in(rst_n), .req_in(mreq), .we_in(mwe), .addr_in(maddr),
    .wdata_in(mwd), .slow_in(slow), .rdata_out(mrd), .ack_out(mack), .acc_out(acc),
    .order_out(obad));

  // record word pattern, trap set and map base 80h in word 25
  function automatic logic [31:0] nw(input int b, input int i);
    return (i == 25 ? 32'h0080_0001 : 32'h5A00_0000 + i * 32'h0001_0101) + b;
  endfunction

  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus access held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  task automatic rchk(input logic [5:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(q, x);
  endtask

  // issue a command and catch the fault pulses with done
  task automatic cmd(input logic [31:0] c);
    int n;
    n = 0;
    bus(1'b1, `TSR_A_CTRL, c);
    while (done !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    fg = gp;
    fd = db;
    ft = ts;
    if (n >= 400) chk(32'h0, 32'h1);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // watchdog against a hung handshake
  initial begin
    #100000;
    fails++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 6'h0;
    wd = 32'h0;
    slow = 1'b1;
    for (int k = 0; k < 1024; k++) tsr_mem_model_i.mem[k] = 32'h7700_0000 + k;
    for (int i = 0; i < 28; i++) begin
      tsr_mem_model_i.mem[256 + i] = nw(256, i);
      tsr_mem_model_i.mem[512 + i] = nw(512, i);
    end
    // map: ports 12..15 set, all-ones byte past the end
    tsr_mem_model_i.mem[288] = 32'h0000_F000;
    tsr_mem_model_i.mem[289] = 32'h0;
    tsr_mem_model_i.mem[290] = 32'h0000_00FF;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`TSR_A_STATUS, 32'h0);
    bus(1'b1, 6'h3F, 32'hFFFF_FFFF);
    rchk(6'h3F, 32'h0);
    // first switch with slow memory
    for (int i = 0; i < 27; i++) bus(1'b1, 6'(`TSR_A_CTX + i), 32'hE000_0000 + i);
    bus(1'b1, `TSR_A_OLD_BASE, 32'h0);
    bus(1'b1, `TSR_A_NEW_BASE, 32'h400);
    bus(1'b1, `TSR_A_NEW_LIMIT, 32'h87);
    bus(1'b1, `TSR_A_CFG, 32'h0);
    cmd(32'h1);
    chk({ft, fd, obad}, 32'h2);
    for (int i = 0; i < 28; i++) begin
      v = tsr_mem_model_i.mem[i];
      e = (i == 0 || (i > 7 && i < 24)) ? 32'hE000_0000 + i : 32'h7700_0000 + i;
      if (i == 0 || (i > 17 && i < 24)) begin
        v[31:16] = 16'h0;
        e[31:16] = 16'h0;
      end
      chk(v, e);
    end
    for (int i = 0; i < 25; i++) begin
      e = nw(256, i);
      if (i > 17) e[31:16] = 16'h0;
      rchk(6'(`TSR_A_CTX + i), e);
    end
    bus(1'b0, 6'(`TSR_A_CTX + 25), 32'h0);
    chk(q[31:16], 32'h80);
    rchk(`TSR_A_CUR_BASE, 32'h400);
    rchk(`TSR_A_CUR_LIMIT, 32'h87);
    // port checks over privilege, size and limit cases, then redirect lookups
    for (int i = 0; i < 14; i++) begin
      bus(1'b1, `TSR_A_CFG, 32'(io_cfg[i]));
      bus(1'b1, `TSR_A_IO_REQ, 32'(io_req[i]));
      a0 = acc;
      cmd(32'h2);
      chk(fg, io_gp[i]);
      bus(1'b0, `TSR_A_STATUS, 32'h0);
      chk(q[`TSR_S_GRANT], !io_gp[i]);
      if (i < 3) chk(32'(acc - a0), i == 2 ? 32'h2 : 32'h0);
    end
    bus(1'b1, 6'(`TSR_A_CTX + 25), 32'hE000_0001);
    bus(1'b1, `TSR_A_IO_REQ, 32'h0);
    cmd(32'h2);
    chk(fg, 1'b1);
    // too-short records, without and with shadow stacks
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, `TSR_A_CFG, 32'(i));
      bus(1'b1, `TSR_A_NEW_LIMIT, i ? 32'h6A : 32'h66);
      bus(1'b1, `TSR_A_NEW_BASE, 32'h800);
      a0 = acc;
      cmd(32'h1);
      chk(ft, 1'b1);
      chk(32'(acc - a0), 32'h0);
    end
    slow <= 1'b0;
    bus(1'b1, `TSR_A_OLD_BASE, 32'h400);
    bus(1'b1, `TSR_A_NEW_LIMIT, 32'h6B);
    cmd(32'h1);
    chk(ft, 1'b0);
    rchk(6'(`TSR_A_CTX + 26), nw(512, 26));
    chk(tsr_mem_model_i.mem[282], nw(256, 26));
    chk(tsr_mem_model_i.mem[283], nw(256, 27));
    // load task register touches no memory
    a0 = acc;
    bus(1'b1, `TSR_A_TASK_PTR, 32'h28);
    bus(1'b1, `TSR_A_NEW_BASE, 32'hC00);
    cmd(32'h4);
    chk(32'(acc - a0), 32'h0);
    bus(1'b0, `TSR_A_STATUS, 32'h0);
    chk(q[`TSR_S_TBUSY], 1'b1);
    rchk(`TSR_A_CUR_BASE, 32'hC00);
    complete_run();
  end
endmodule

// [testbench/tsr_mem_model.sv]
// Purpose: record memory on the far side of the task state unit
// Assumes: word array indexed by byte address bits 11:2
// Notes:   ack after one or four cycles; read word scrambles when idle
module tsr_mem_model (
  input  wire logic        clk_in,    // system clock
  input  wire logic        rst_n_in,  // async reset, low
  input  wire logic        req_in,    // access request
  input  wire logic        we_in,     // write access
  input  wire logic [31:0] addr_in,   // byte address
  input  wire logic [31:0] wdata_in,  // write word
  input  wire logic        slow_in,   // long latency
  output logic      [31:0] rdata_out, // read word
  output logic             ack_out,   // access done
  output int               acc_out,   // accesses served
  output logic             order_out  // write seen after a read
);
  logic [31:0] mem [1024];
  int          wt;
  logic        rd_seen;

  // serve each access whole, never faulting
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      wt <= 0;
      acc_out <= 0;
      rd_seen <= 1'b0;
      order_out <= 1'b0;
      rdata_out <= 32'hA5A5_5A5A;
    end else if (ack_out || !req_in) begin
      ack_out <= 1'b0;
      wt <= 0;
      rdata_out <= ~rdata_out;
    end else if (wt < (slow_in ? 3 : 0)) begin
      wt <= wt + 1;
    end else begin
      ack_out <= 1'b1;
      acc_out <= acc_out + 1;
      if (we_in) begin
        mem[addr_in[11:2]] <= wdata_in;
        order_out <= order_out | rd_seen;
      end else begin
        rdata_out <= mem[addr_in[11:2]];
        rd_seen <= 1'b1;
      end
    end
  end
endmodule
